// *** hw/emci_ctrl.sv ***
/*
  Programmer controller: reads, identifies and programs a byte-wide
  one-time-write memory through its pins.
  Assumes board switches turn supply enables into the real voltage levels
  and the data pins form a shared wire resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none
module emci_ctrl
  import emci_pkg::*;
#(
  parameter int                PULSE_CYC  = PW_CYC,
  parameter int                TRIES_MAX  = MAX_TRIES,
  // Identification values are arbitrary
  parameter logic [DATA_W-1:0] MAKER_CODE = 8'h5A,
  parameter logic [DATA_W-1:0] PART_CODE  = 8'h3C,
  parameter logic [DATA_W-1:0] PART_ALT   = 8'h3B
)(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire emci_op_t          cmd_op,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_data,
  output logic                   rsp_valid,
  output logic                   rsp_fail,
  output logic [DATA_W-1:0]      rsp_data,
  output logic                   id_ok,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic [DATA_W-1:0]      mem_dq_out,
  input  wire logic [DATA_W-1:0] mem_dq_in,
  output logic                   mem_dq_oe_n,
  output logic                   mem_ce_n,
  output logic                   mem_oe_n,
  output logic                   prog_supply_en,
  output logic                   program_core_supply_en,
  output logic                   identifier_hv_pin_en
);
  ////////////////////////////////////////////////////////////////////////////////
  // Parameter checks
  if (PULSE_CYC < 1 || PULSE_CYC > 65535) begin : g_bad_pulse
    $error("PULSE_CYC out of range");
  end
  if (TRIES_MAX < 1 || TRIES_MAX > 31) begin : g_bad_tries
    $error("TRIES_MAX out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    emci_state_t       state;
    emci_op_t          op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic [4:0]        tries;
    logic              id_phase;
    logic              maker_ok;
    logic              id_ok;
    logic              ce_n;
    logic              oe_n;
    logic              dq_oe_n;
    logic              vpp;
    logic              marg;
    logic              idhv;
    logic              rsp_valid;
    logic              rsp_fail;
  } emci_ctl_st_t;

  localparam emci_ctl_st_t RST_VAL = '{
    state: S_IDLE, op: OP_READ, addr: '0, wdata: '0, rdata: '0, dq_s1: '0,
    dq_s2: '0, tries: '0, id_phase: 1'b0, maker_ok: 1'b0, id_ok: 1'b0,
    ce_n: 1'b1, oe_n: 1'b1, dq_oe_n: 1'b1, vpp: 1'b0, marg: 1'b0,
    idhv: 1'b0, rsp_valid: 1'b0, rsp_fail: 1'b0};

  emci_ctl_st_t cur_reg;
  emci_ctl_st_t cur_next;
  emci_tmr_if   tmr ();

  emci_timer u_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .t        (tmr)
  );

  function automatic logic [TMR_W-1:0] wait_of(emci_state_t s);
    int c;
    c = 1;
    unique case (s)
      S_RD_ADDR:  c = ACC_CYC;
      S_RD_OE:    c = OE_CYC;
      S_RD_END:   c = DF_CYC;
      S_PG_SUP:   c = SUP_CYC;
      S_PG_SET:   c = SET_CYC;
      S_PG_PULSE: c = PULSE_CYC;
      S_PG_HOLD:  c = HOLD_CYC;
      S_PG_VER:   c = VOE_CYC;
      S_PG_CHK:   c = DFP_CYC;
      S_PG_DOWN:  c = DOWN_CYC;
      S_IDLE:     c = 1;
    endcase
    return TMR_W'(c - 1);
  endfunction

  assign tmr.start = (cur_next.state != cur_reg.state);
  assign tmr.load  = wait_of(cur_next.state);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    cur_next = cur_reg;
    cur_next.dq_s1 = mem_dq_in;
    cur_next.dq_s2 = cur_reg.dq_s1;
    cur_next.rsp_valid = 1'b0;
    unique case (cur_reg.state)
      S_IDLE: begin
        if (cmd_valid) begin
          cur_next.addr     = cmd_addr;
          cur_next.wdata    = cmd_data;
          cur_next.op       = cmd_op;
          cur_next.tries    = '0;
          cur_next.id_phase = 1'b0;
          cur_next.rsp_fail = 1'b0;
          unique case (cmd_op)
            OP_READ: begin
              cur_next.ce_n  = 1'b0;
              cur_next.state = S_RD_ADDR;
            end
            OP_IDENT: begin
              cur_next.addr  = ID_MAKER_ADDR;
              cur_next.idhv  = 1'b1;
              cur_next.ce_n  = 1'b0;
              cur_next.state = S_RD_ADDR;
            end
            OP_PROG: begin
              if (!cur_reg.id_ok) begin
                cur_next.rsp_valid = 1'b1;
                cur_next.rsp_fail  = 1'b1;
              end else begin
                cur_next.marg  = 1'b1;
                cur_next.vpp   = 1'b1;
                cur_next.state = S_PG_SUP;
              end
            end
            default: begin
              cur_next.rsp_valid = 1'b1;
              cur_next.rsp_fail  = 1'b1;
            end
          endcase
        end
      end
      S_RD_ADDR: begin
        if (tmr.done) begin
          cur_next.oe_n  = 1'b0;
          cur_next.state = S_RD_OE;
        end
      end
      S_RD_OE: begin
        if (tmr.done) begin
          cur_next.rdata = cur_reg.dq_s2;
          cur_next.ce_n  = 1'b1;
          cur_next.oe_n  = 1'b1;
          cur_next.state = S_RD_END;
        end
      end
      S_RD_END: begin
        if (tmr.done) begin
          if (cur_reg.op == OP_IDENT && !cur_reg.id_phase) begin
            cur_next.maker_ok = (cur_reg.rdata == MAKER_CODE);
            cur_next.id_phase = 1'b1;
            cur_next.addr     = ID_PART_ADDR;
            cur_next.ce_n     = 1'b0;
            cur_next.state    = S_RD_ADDR;
          end else begin
            if (cur_reg.op == OP_IDENT) begin
              cur_next.id_ok    = cur_reg.maker_ok &&
                                  (cur_reg.rdata == PART_CODE ||
                                   cur_reg.rdata == PART_ALT);
              cur_next.rsp_fail = !cur_next.id_ok;
              cur_next.idhv     = 1'b0;
            end
            cur_next.rsp_valid = 1'b1;
            cur_next.state     = S_IDLE;
          end
        end
      end
      S_PG_SUP: begin
        if (tmr.done) begin
          cur_next.dq_oe_n = 1'b0;
          cur_next.state   = S_PG_SET;
        end
      end
      S_PG_SET: begin
        if (tmr.done) begin
          cur_next.ce_n  = 1'b0;
          cur_next.state = S_PG_PULSE;
        end
      end
      S_PG_PULSE: begin
        if (tmr.done) begin
          cur_next.ce_n  = 1'b1;
          cur_next.tries = cur_reg.tries + 5'h01;
          cur_next.state = S_PG_HOLD;
        end
      end
      S_PG_HOLD: begin
        if (tmr.done) begin
          cur_next.dq_oe_n = 1'b1;
          cur_next.oe_n    = 1'b0;
          cur_next.state   = S_PG_VER;
        end
      end
      S_PG_VER: begin
        if (tmr.done) begin
          cur_next.rdata = cur_reg.dq_s2;
          cur_next.oe_n  = 1'b1;
          cur_next.state = S_PG_CHK;
        end
      end
      S_PG_CHK: begin
        if (tmr.done) begin
          if (cur_reg.rdata == cur_reg.wdata) begin
            cur_next.vpp   = 1'b0;
            cur_next.state = S_PG_DOWN;
          end else if (cur_reg.tries == 5'(TRIES_MAX)) begin
            cur_next.rsp_fail = 1'b1;
            cur_next.vpp      = 1'b0;
            cur_next.state    = S_PG_DOWN;
          end else begin
            cur_next.dq_oe_n = 1'b0;
            cur_next.state   = S_PG_SET;
          end
        end
      end
      S_PG_DOWN: begin
        if (tmr.done) begin
          cur_next.marg      = 1'b0;
          cur_next.rsp_valid = 1'b1;
          cur_next.state     = S_IDLE;
        end
      end
      default: begin
        cur_next = RST_VAL;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cur_reg <= RST_VAL;
    end else begin
      cur_reg <= cur_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign cmd_ready              = (cur_reg.state == S_IDLE);
  assign rsp_valid              = cur_reg.rsp_valid;
  assign rsp_fail               = cur_reg.rsp_fail;
  assign rsp_data               = cur_reg.rdata;
  assign id_ok                  = cur_reg.id_ok;
  assign mem_addr               = cur_reg.addr;
  assign mem_dq_out             = cur_reg.wdata;
  assign mem_dq_oe_n            = cur_reg.dq_oe_n;
  assign mem_ce_n               = cur_reg.ce_n;
  assign mem_oe_n               = cur_reg.oe_n;
  assign prog_supply_en         = cur_reg.vpp;
  assign program_core_supply_en = cur_reg.marg;
  assign identifier_hv_pin_en   = cur_reg.idhv;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [TMR_W-1:0] pw_cnt_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pw_cnt_reg <= '0;
    end else if (!mem_ce_n && prog_supply_en) begin
      pw_cnt_reg <= pw_cnt_reg + 16'h0001;
    end else begin
      pw_cnt_reg <= '0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_pulse_end;
    prog_supply_en && $rose(mem_ce_n);
  endsequence
  sequence s_verify_start;
    ##[1:400] (!mem_oe_n && mem_ce_n && program_core_supply_en);
  endsequence

  a_pulse_gate_high: assert property (
    (prog_supply_en && !mem_ce_n) |-> (mem_oe_n && !mem_dq_oe_n))
    else $error("Program pulse without gate high and data driven");
  a_pulse_width_exact: assert property (
    s_pulse_end |-> (pw_cnt_reg == TMR_W'(PULSE_CYC)))
    else $error("Program pulse width wrong");
  a_pulse_then_verify: assert property (s_pulse_end |-> s_verify_start)
    else $error("No verify after program pulse");
  a_verify_margin: assert property (
    (prog_supply_en && !mem_oe_n) |-> (mem_ce_n && program_core_supply_en && mem_dq_oe_n))
    else $error("Verify without margin supply or select high");
  a_inhibit_idle: assert property (
    (prog_supply_en && cur_reg.state != S_PG_PULSE) |-> mem_ce_n)
    else $error("Select low outside program pulse");
  a_ident_lines_low: assert property (
    (identifier_hv_pin_en && !mem_ce_n) |-> (mem_addr[ADDR_W-1:1] == '0 && !prog_supply_en))
    else $error("Identifier read with upper address nonzero");
  a_prog_needs_id: assert property ($rose(prog_supply_en) |-> id_ok)
    else $error("Program started without identified part");
  a_tries_bound: assert property (cur_reg.tries <= 5'(TRIES_MAX))
    else $error("Too many program attempts");
  a_read_bus_free: assert property (
    (!mem_oe_n) |-> (mem_dq_oe_n ##1 mem_dq_oe_n))
    else $error("Controller drives data while reading");
  a_vpp_within_vcp: assert property (prog_supply_en |-> program_core_supply_en)
    else $error("Program supply raised without margin supply");
endmodule
`default_nettype wire

// *** hw/emci_pkg.sv ***
/*
  Constants, timing counts and enumerations for the memory programmer controller.
  Assumes a 100 MHz core clock; all waits below are derived from that period.
*/
package emci_pkg;

  localparam int CLK_NS     = 10;
  localparam int ADDR_W     = 15;
  localparam int DATA_W     = 8;
  localparam int TMR_W      = 16;
  localparam int SYNC_LAT   = 2;

  // Device and programming times in ns
  localparam int T_ACC_NS   = 120;
  localparam int T_OE_NS    = 55;
  localparam int T_DF_NS    = 30;
  localparam int T_VCS_NS   = 2000;
  localparam int T_VPS_NS   = 2000;
  localparam int T_SET_NS   = 2000;
  localparam int T_HOLD_NS  = 2000;
  localparam int T_PW_NS    = 100000;
  localparam int T_VOE_NS   = 150;
  localparam int T_DFP_NS   = 130;

  // Cycle counts, rounded up except PW_CYC, which is rounded down
  localparam int ACC_CYC    = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int OE_CYC     = (T_OE_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT;
  localparam int DF_CYC     = (T_DF_NS + CLK_NS - 1) / CLK_NS;
  localparam int SUP_CYC    = (T_VCS_NS + T_VPS_NS + CLK_NS - 1) / CLK_NS;
  localparam int SET_CYC    = (T_SET_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC   = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int PW_CYC     = T_PW_NS / CLK_NS;
  localparam int VOE_CYC    = (T_VOE_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT;
  localparam int DFP_CYC    = (T_DFP_NS + CLK_NS - 1) / CLK_NS;
  localparam int DOWN_CYC   = (T_VCS_NS + CLK_NS - 1) / CLK_NS;
  localparam int MAX_TRIES  = 25;

  localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 15'h0000;
  localparam logic [ADDR_W-1:0] ID_PART_ADDR  = 15'h0001;

  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_PROG  = 2'h1,
    OP_IDENT = 2'h2
  } emci_op_t;

  typedef enum logic [3:0] {
    S_IDLE     = 4'h0,
    S_RD_ADDR  = 4'h1,
    S_RD_OE    = 4'h3,
    S_RD_END   = 4'h2,
    S_PG_SUP   = 4'h6,
    S_PG_SET   = 4'h7,
    S_PG_PULSE = 4'h5,
    S_PG_HOLD  = 4'h4,
    S_PG_VER   = 4'hC,
    S_PG_CHK   = 4'hD,
    S_PG_DOWN  = 4'hF
  } emci_state_t;

endpackage

// *** hw/emci_timer.sv ***
/*
  Down counter for controller waits.
  Assumes start is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module emci_timer
  import emci_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  rst_n,
  emci_tmr_if.tmr    t
);
  typedef struct packed {
    logic [TMR_W-1:0] cnt;
  } emci_tmr_st_t;

  emci_tmr_st_t cur_reg;
  emci_tmr_st_t cur_next;

  always_comb begin
    cur_next = cur_reg;
    if (t.start) begin
      cur_next.cnt = t.load;
    end else if (cur_reg.cnt != '0) begin
      cur_next.cnt = cur_reg.cnt - 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign t.done = (cur_reg.cnt == '0);
endmodule
`default_nettype wire

// *** hw/emci_tmr_if.sv ***
/*
  Wait timer carrier between the controller and its timer.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface emci_tmr_if;
  import emci_pkg::*;
  logic             start;
  logic [TMR_W-1:0] load;
  logic             done;
  modport ctl (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface
`default_nettype wire

// *** tb/emci_mem_model.sv ***
/*
  Behavioural model of the byte-wide one-time-write memory.
  Assumes the bench resolves the shared data wire and feeds it back on bus.
*/
`timescale 1ns/1ps
`default_nettype none
module emci_mem_model
  import emci_pkg::*;
#(
  parameter logic [DATA_W-1:0] MAKER = 8'h5A,
  parameter logic [DATA_W-1:0] PART  = 8'h3C,
  parameter logic [DATA_W-1:0] ALT   = 8'h3B
)(
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              ce_n,
  input  wire logic              oe_n,
  input  wire logic              vpp,
  input  wire logic              margin,
  input  wire logic              hv,
  input  wire logic [DATA_W-1:0] bus,
  input  wire logic              use_alt,
  input  wire logic              bad_maker,
  output logic [DATA_W-1:0]      dq,
  output logic                   dq_en,
  output logic                   standby
);
  logic [DATA_W-1:0] mem [0:32767];
  logic [DATA_W-1:0] code;
  wire  [ADDR_W+3:0] now_v;
  wire  [ADDR_W+3:0] late_v;

  initial begin
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 8'hFF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read, verify and identifier output
  assign now_v = {ce_n, oe_n, hv, vpp, addr};
  assign #50 late_v = now_v;
  assign standby = ce_n;
  assign dq_en = !oe_n && (vpp ? (ce_n && margin) : !ce_n);

  // Identifier codes under high voltage with vpp low, array contents otherwise
  assign code = !(hv && !vpp) ? mem[addr] :
                addr[0] ? (use_alt ? ALT : PART) : (bad_maker ? ~MAKER : MAKER);

  // Unsettled or released data shows the inverse
  assign dq = (dq_en && late_v === now_v) ? code : ~code;

  ////////////////////////////////////////////////////////////////////////////////
  // Programming clears bits only
  always @(posedge ce_n) begin
    if (vpp && margin && oe_n && !hv) begin
      mem[addr] = mem[addr] & bus;
    end
  end
endmodule
`default_nettype wire

// *** tb/eprom_mode_control_interface_tb.sv ***
/*
  Self-checking bench for the programmer controller.
  Assumes the memory model answers within 55 ns of the output gate falling.
*/
`timescale 1ns/1ps
`default_nettype none
module eprom_mode_control_interface_tb;
  import emci_pkg::*;
  // Identification values are arbitrary
  localparam logic [DATA_W-1:0] MAKER_C = 8'h5A;
  localparam logic [DATA_W-1:0] PART_C  = 8'h3C;
  localparam logic [DATA_W-1:0] ALT_C   = 8'h3B;
  localparam int                PULSES  = 20;
  localparam int                TRIES   = 25;

  logic              core_clk, rst_n, cmd_valid, cmd_ready, rsp_valid, rsp_fail, id_ok;
  logic              mem_dq_oe_n, mem_ce_n, mem_oe_n, prog_supply_en;
  logic              program_core_supply_en, identifier_hv_pin_en;
  logic              use_alt, bad_maker, m_en, m_standby;
  emci_op_t          cmd_op;
  logic [ADDR_W-1:0] cmd_addr, mem_addr;
  logic [DATA_W-1:0] cmd_data, rsp_data, mem_dq_out, m_dq, wire_dq;
  logic [DATA_W-1:0] shadow [0:32767];
  int                err_count, checked, pulses, lat;

  assign wire_dq = !mem_dq_oe_n ? mem_dq_out : m_dq;

  emci_ctrl #(.PULSE_CYC(PULSES), .TRIES_MAX(TRIES), .MAKER_CODE(MAKER_C),
              .PART_CODE(PART_C), .PART_ALT(ALT_C)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_fail(rsp_fail), .rsp_data(rsp_data), .id_ok(id_ok), .mem_addr(mem_addr),
    .mem_dq_out(mem_dq_out), .mem_dq_in(wire_dq), .mem_dq_oe_n(mem_dq_oe_n),
    .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n), .prog_supply_en(prog_supply_en),
    .program_core_supply_en(program_core_supply_en),
    .identifier_hv_pin_en(identifier_hv_pin_en));

  emci_mem_model #(.MAKER(MAKER_C), .PART(PART_C), .ALT(ALT_C)) mem_u (
    .addr(mem_addr), .ce_n(mem_ce_n), .oe_n(mem_oe_n), .vpp(prog_supply_en),
    .margin(program_core_supply_en), .hv(identifier_hv_pin_en), .bus(wire_dq),
    .use_alt(use_alt), .bad_maker(bad_maker), .dq(m_dq), .dq_en(m_en),
    .standby(m_standby));

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    if (err_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  function automatic logic [DATA_W-1:0] stored(input logic [ADDR_W-1:0] a);
    return shadow[a];
  endfunction

  task automatic run(input emci_op_t op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    @(negedge core_clk);
    check("cmd_ready", cmd_ready, 1'b1);
    pulses = 0;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
    lat = n;
    check("standby", m_standby, 1'b1);
    if (n >= 20000) begin
      err_count++;
      conclude();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Pin monitors
  always @(negedge mem_ce_n) begin
    if (prog_supply_en === 1'b1) begin
      pulses++;
      check("pulse gate", mem_oe_n, 1'b1);
      check("pulse drive", mem_dq_oe_n, 1'b0);
      check("pulse core", program_core_supply_en, 1'b1);
    end
  end

  always @(negedge core_clk) begin
    if (rst_n === 1'b1 && mem_dq_oe_n === 1'b0) begin
      check("contention", m_en, 1'b0);
    end
    if (identifier_hv_pin_en === 1'b1 && mem_ce_n === 1'b0) begin
      check("id high addr", mem_addr[ADDR_W-1:1], '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog, main sequence
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    conclude();
  end

  initial begin
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic              bad;
    err_count = 0;
    checked = 0;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_READ;
    cmd_addr = '0;
    cmd_data = '0;
    use_alt = 1'b0;
    bad_maker = 1'b0;
    for (int i = 0; i < 32768; i++) begin
      shadow[i] = 8'hFF;
    end
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    void'($urandom(74322));
    check("ce_n rst", mem_ce_n, 1'b1);
    check("dq_oe_n rst", mem_dq_oe_n, 1'b1);
    check("vpp rst", prog_supply_en, 1'b0);
    check("id_ok rst", id_ok, 1'b0);
    run(OP_PROG, 15'h0010, 8'h00);
    check("prog no id", rsp_fail, 1'b1);
    check("prog no id pulses", pulses, 0);
    run(emci_op_t'(2'h3), 15'h0000, 8'h00);
    check("bad op", rsp_fail, 1'b1);
    check("bad op pulses", pulses, 0);
    bad_maker = 1'b1;
    run(OP_IDENT, 15'h0000, 8'h00);
    check("bad maker", id_ok, 1'b0);
    bad_maker = 1'b0;
    use_alt = 1'b1;
    run(OP_IDENT, 15'h0000, 8'h00);
    check("alt id", id_ok, 1'b1);
    check("alt code", rsp_data, ALT_C);
    use_alt = 1'b0;
    run(OP_IDENT, 15'h1234, 8'h00);
    check("id", id_ok, 1'b1);
    check("part code", rsp_data, PART_C);
    for (int i = 0; i < 7; i++) begin
      a = (i == 0) ? 15'h0000 : (i == 1) ? 15'h0001 : (i == 2) ? 15'h7FFF : 15'($urandom);
      d = (i == 6) ? 8'hFF : 8'($urandom) & 8'hFE;
      if (i == 6) begin
        a = 15'h0000;
      end
      run(OP_READ, a, 8'h00);
      check("read", rsp_data, stored(a));
      check("read cycles", lat, ACC_CYC + OE_CYC + DF_CYC);
      bad = (stored(a) & d) != d;
      run(OP_PROG, a, d);
      check("prog fail", rsp_fail, bad);
      check("prog pulses", pulses, bad ? TRIES : 1);
      check("prog data", rsp_data, stored(a) & d);
      shadow[a] = stored(a) & d;
      run(OP_READ, a, 8'h00);
      check("read back", rsp_data, stored(a));
      check("supply off", prog_supply_en, 1'b0);
    end
    // Reset in the middle of a program command
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_op = OP_PROG;
    cmd_addr = 15'h0100;
    cmd_data = 8'h00;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    repeat (50) @(negedge core_clk);
    check("vpp up", prog_supply_en, 1'b1);
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    check("vpp rst2", prog_supply_en, 1'b0);
    check("ce_n rst2", mem_ce_n, 1'b1);
    check("id_ok rst2", id_ok, 1'b0);
    run(OP_PROG, 15'h0100, 8'h00);
    check("prog after rst", rsp_fail, 1'b1);
    check("prog after rst pulses", pulses, 0);
    conclude();
  end
endmodule
`default_nettype wire
